/* File: pkg/dcff_cfg.svh */
// Constants for the dual clock fall-through buffer
`ifndef DCFF_CFG_SVH
`define DCFF_CFG_SVH

`define DCFF_DATA_WIDTH 8
`define DCFF_DEPTH 16
`define DCFF_FLAG_SYNC_STAGES 3
`define DCFF_STROBE_COUNT 4
`define DCFF_FULL_N_RST 1'h1
`define DCFF_EMPTY_N_RST 1'h0
`define DCFF_FULL_CHAIN_RST 1'h1
`define DCFF_EMPTY_CHAIN_RST 1'h0
`define DCFF_STROBE_RST 4'h0
`define DCFF_CTL_RST 5'h1F
`define DCFF_PEND_RST 1'h0

`endif

/* File: pkg/dcff_pkg.sv */
// Types shared by the dual clock fall-through buffer
`default_nettype none

package dcff_pkg;

  typedef enum logic [0:0] {
    DCFF_STYLE_EDGE = 1'b0,
    DCFF_STYLE_SYNC = 1'b1
  } dcff_style_type;

  typedef struct packed {
    logic wr_clk;
    logic rd_clk;
    logic wr_en_n;
    logic rd_en_n;
    logic style;
  } dcff_ctl_type;

  typedef struct packed {
    logic stage_strobe_first;
    logic stage_strobe_second;
    logic stage_strobe_third;
    logic stage_strobe_fourth;
  } dcff_strobe_type;

endpackage : dcff_pkg

`default_nettype wire

/* File: logic/dcff_fall_fifo.sv */
// Fall-through latch chain with one status flip-flop per stage
`timescale 1ns/1ps
`default_nettype none
`include "dcff_cfg.svh"

module dcff_fall_fifo #(
  parameter int WIDTH = `DCFF_DATA_WIDTH,
  parameter int DEPTH = `DCFF_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count,
  output logic [DEPTH-1:0] strobe
);

  logic [WIDTH-1:0] stage_data [DEPTH];
  logic [WIDTH-1:0] shift_in [DEPTH];
  logic [DEPTH-1:0] stage_full;
  logic [DEPTH-1:0] take;
  logic [DEPTH-1:0] leave;
  logic [DEPTH-1:0] next_full;
  logic [CW-1:0] next_count;
  wire logic in_fire;
  wire logic out_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Stage strobes: stage DEPTH-1 is the entry, stage 0 faces the output
  // read shift
  assign leave[0] = out_ready && stage_full[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      if (i > 0) begin : g_up
        assign leave[i] = take[i-1];
      end
      if (i < DEPTH - 1) begin : g_mid
        assign take[i] = stage_full[i+1] && (!stage_full[i] || leave[i]);
        assign shift_in[i] = stage_data[i+1];
      end else begin : g_top
        assign take[i] = in_valid && (!stage_full[i] || leave[i]);
        assign shift_in[i] = in_data;
      end
      assign next_full[i] = take[i] || (stage_full[i] && !leave[i]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Storage and status
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage_full <= '0;
    end else begin
      stage_full <= next_full;
    end
  end

  always_ff @(posedge mclk) begin
    for (int k = 0; k < DEPTH; k++) begin
      if (take[k]) begin
        stage_data[k] <= shift_in[k];
      end
    end
  end

  assign in_fire = in_valid && in_ready;
  assign out_fire = leave[0];
  assign next_count = count + CW'(in_fire) - CW'(out_fire);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign in_ready = !stage_full[DEPTH-1] || leave[DEPTH-1];
  assign out_valid = stage_full[0];
  assign out_data = stage_data[0];
  assign strobe = take;

endmodule : dcff_fall_fifo

`default_nettype wire

/* File: logic/dcff_top.sv */
// Dual clock buffer with edge-driven and synchronous styles
`timescale 1ns/1ps
`default_nettype none
`include "dcff_cfg.svh"

module dcff_top #(
  parameter int WIDTH = `DCFF_DATA_WIDTH,
  parameter int DEPTH = `DCFF_DEPTH,
  parameter int SYNC_STAGES = `DCFF_FLAG_SYNC_STAGES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_clk,
  input wire logic rd_clk,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic style_sync,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data,
  output logic full_n,
  output logic empty_n,
  output dcff_pkg::dcff_strobe_type stage_strobes
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);
  localparam logic [CW-1:0] LAST_FREE = CW'(DEPTH - 1);
  localparam logic [CW-1:0] ONE_WORD = CW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, then an edge detect on the second
  dcff_pkg::dcff_ctl_type ctl_pins;
  dcff_pkg::dcff_ctl_type ctl_meta;
  dcff_pkg::dcff_ctl_type ctl_sync;
  dcff_pkg::dcff_ctl_type ctl_prev;
  logic [WIDTH-1:0] data_meta;
  logic [WIDTH-1:0] data_sync;

  assign ctl_pins.wr_clk = wr_clk;
  assign ctl_pins.rd_clk = rd_clk;
  assign ctl_pins.wr_en_n = wr_en_n;
  assign ctl_pins.rd_en_n = rd_en_n;
  assign ctl_pins.style = style_sync;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_meta <= `DCFF_CTL_RST;
      ctl_sync <= `DCFF_CTL_RST;
      ctl_prev <= `DCFF_CTL_RST;
    end else begin
      ctl_meta <= ctl_pins;
      ctl_sync <= ctl_meta;
      ctl_prev <= ctl_sync;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= wr_data;
      data_sync <= data_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  wire logic wr_rise;
  wire logic rd_rise;
  wire logic sync_style;
  wire logic wr_request;
  wire logic rd_request;
  wire logic wr_accept;
  wire logic rd_accept;
  wire logic full_now;
  wire logic room_for_capture;

  assign wr_rise = ctl_sync.wr_clk && !ctl_prev.wr_clk;
  assign rd_rise = ctl_sync.rd_clk && !ctl_prev.rd_clk;
  assign sync_style = (dcff_pkg::dcff_style_type'(ctl_sync.style) == dcff_pkg::DCFF_STYLE_SYNC);

  assign wr_request = wr_rise && (!sync_style || !ctl_sync.wr_en_n);
  assign rd_request = rd_rise && (!sync_style || !ctl_sync.rd_en_n);

  ////////////////////////////////////////////////////////////////////////////
  // Capture register feeding the latch chain
  logic pend;
  logic [WIDTH-1:0] pend_data;
  logic next_pend;
  wire logic chain_ready;
  wire logic chain_valid;
  wire logic [WIDTH-1:0] chain_data;
  wire logic [CW-1:0] chain_count;
  wire logic [DEPTH-1:0] chain_strobe;
  wire logic [CW-1:0] occupancy;

  assign occupancy = chain_count + CW'(pend);
  assign full_now = (occupancy >= FULL_LEVEL);
  assign room_for_capture = !pend || chain_ready;

  assign wr_accept = wr_request && !full_now && room_for_capture;
  assign rd_accept = rd_request && chain_valid;

  // Set wins over drain so a capture in the draining cycle is kept
  assign next_pend = wr_accept || (pend && !chain_ready);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend <= `DCFF_PEND_RST;
    end else begin
      pend <= next_pend;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_accept) begin
      pend_data <= data_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fall-through latch chain
  // order kept
  dcff_fall_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_chain (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(pend),
    .in_ready(chain_ready),
    .in_data(pend_data),
    .out_valid(chain_valid),
    .out_ready(rd_accept),
    .out_data(chain_data),
    .count(chain_count),
    .strobe(chain_strobe)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_accept) begin
      rd_data <= chain_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag sources
  wire logic raw_not_full;
  wire logic raw_not_empty;
  wire logic fills_now;
  wire logic empties_now;

  assign raw_not_full = !full_now;
  assign raw_not_empty = chain_valid;
  assign fills_now = wr_accept && (occupancy == LAST_FREE);
  assign empties_now = rd_accept && (chain_count == ONE_WORD) && !pend;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous style flag chains, stepped by the flag's own clock
  logic [SYNC_STAGES-1:0] full_chain;
  logic [SYNC_STAGES-1:0] empty_chain;
  wire logic full_chain_in;
  wire logic empty_chain_in;
  wire logic sync_full_n;
  wire logic sync_empty_n;

  assign full_chain_in = raw_not_full && !fills_now;
  assign empty_chain_in = raw_not_empty && !empties_now;

  assign sync_full_n = full_chain_in && full_chain[SYNC_STAGES-1];
  assign sync_empty_n = empty_chain_in && empty_chain[SYNC_STAGES-1];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      full_chain <= {SYNC_STAGES{`DCFF_FULL_CHAIN_RST}};
    end else if (wr_rise) begin
      full_chain <= {full_chain[SYNC_STAGES-2:0], full_chain_in};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      empty_chain <= {SYNC_STAGES{`DCFF_EMPTY_CHAIN_RST}};
    end else if (rd_rise) begin
      empty_chain <= {empty_chain[SYNC_STAGES-2:0], empty_chain_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag selection between the two styles
  wire logic next_full_n;
  wire logic next_empty_n;
  wire logic edge_full_n;
  wire logic edge_empty_n;

  assign edge_full_n = raw_not_full;
  assign edge_empty_n = raw_not_empty;

  assign next_full_n = sync_style ? (wr_rise ? sync_full_n : full_n) : edge_full_n;
  assign next_empty_n = sync_style ? (rd_rise ? sync_empty_n : empty_n) : edge_empty_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      full_n <= `DCFF_FULL_N_RST;
      empty_n <= `DCFF_EMPTY_N_RST;
    end else begin
      full_n <= next_full_n;
      empty_n <= next_empty_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe monitor: first four stages from the entry side
  dcff_pkg::dcff_strobe_type next_strobes;

  assign next_strobes.stage_strobe_first = chain_strobe[DEPTH-1];
  assign next_strobes.stage_strobe_second = chain_strobe[DEPTH-2];
  assign next_strobes.stage_strobe_third = chain_strobe[DEPTH-3];
  assign next_strobes.stage_strobe_fourth = chain_strobe[DEPTH-4];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage_strobes <= `DCFF_STROBE_RST;
    end else begin
      stage_strobes <= next_strobes;
    end
  end

endmodule : dcff_top

`default_nettype wire

/* File: tb/dcff_checker.sv */
// Port-level timing checks for the dual clock buffer
`timescale 1ns/1ps
`default_nettype none

module dcff_checker #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int SYNC_STAGES = 3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_clk,
  input wire logic rd_clk,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic style_sync,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] rd_data,
  input wire logic full_n,
  input wire logic empty_n,
  input wire dcff_pkg::dcff_strobe_type stage_strobes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_reset_state: assert property ($rose(resetn) |-> full_n && !empty_n && rd_data == '0 && stage_strobes == '0)
    else $error("state after reset release wrong");
  a_read_moves_data: assert property ($changed(rd_data) |-> $past(rd_clk))
    else $error("read data changed without a read clock");
  a_empty_drop_read: assert property ($fell(empty_n) |-> $past(rd_clk))
    else $error("empty flag asserted without a read");
  a_full_set_write: assert property ($fell(full_n) |-> $past(wr_clk))
    else $error("full flag asserted without a write");
  a_full_free_read: assert property (!style_sync && $rose(full_n) |-> $past(rd_clk))
    else $error("full flag released off reader timing");
  a_full_sync_clock: assert property (style_sync && $changed(full_n) |-> $past(wr_clk))
    else $error("full flag moved off write clock");
  a_empty_sync_clock: assert property (style_sync && $changed(empty_n) |-> $past(rd_clk))
    else $error("empty flag moved off read clock");
  a_empty_sync_lag: assert property (style_sync && $rose(empty_n) |-> !$past(empty_n, 16))
    else $error("empty release not synchronised");
  a_full_sync_lag: assert property (style_sync && $rose(full_n) |-> !$past(full_n, 16))
    else $error("full release not delayed");
  a_strobe_chain: assert property (!style_sync && !empty_n && stage_strobes.stage_strobe_first
    |=> stage_strobes.stage_strobe_second ##1 stage_strobes.stage_strobe_third
    ##1 stage_strobes.stage_strobe_fourth)
    else $error("transfer strobes out of turn");
endmodule : dcff_checker

bind dcff_top dcff_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH), .SYNC_STAGES(SYNC_STAGES)) u_chk (
  .mclk(mclk), .resetn(resetn), .wr_clk(wr_clk), .rd_clk(rd_clk), .wr_en_n(wr_en_n),
  .rd_en_n(rd_en_n), .style_sync(style_sync), .wr_data(wr_data), .rd_data(rd_data),
  .full_n(full_n), .empty_n(empty_n), .stage_strobes(stage_strobes));

`default_nettype wire

/* File: tb/dcff_partner.sv */
// Writer and reader logic on the far side of the buffer
`timescale 1ns/1ps
`default_nettype none

module dcff_partner #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic sync_mode,
  input wire logic [WIDTH-1:0] rd_data,
  input wire logic full_n,
  input wire logic empty_n,
  output logic wr_clk,
  output logic rd_clk,
  output logic wr_en_n,
  output logic rd_en_n,
  output logic [WIDTH-1:0] wr_data,
  output logic full_seen,
  output logic empty_seen
);
  logic wr_free;
  logic rd_free;
  logic wr_pulse = 1'b0;
  logic rd_pulse = 1'b0;
  logic full_m;
  logic empty_m;

  // two flops before any flag decision
  always_ff @(posedge mclk) begin
    {full_seen, full_m} <= {full_m, full_n};
    {empty_seen, empty_m} <= {empty_m, empty_n};
  end

  // free-running clocks, phase unrelated to mclk
  initial begin
    wr_free = 1'b0;
    #7;
    forever #160 wr_free = !wr_free;
  end
  initial begin
    rd_free = 1'b0;
    #23;
    forever #160 rd_free = !rd_free;
  end
  assign wr_clk = sync_mode ? wr_free : wr_pulse;
  assign rd_clk = sync_mode ? rd_free : rd_pulse;
  initial {wr_en_n, rd_en_n, wr_data} = {1'b1, 1'b1, {WIDTH{1'b0}}};

  task automatic put_word(input logic [WIDTH-1:0] d);
    wr_data = d;
    if (sync_mode) begin
      // enable low across one write clock rise
      @(negedge wr_free);
      wr_en_n = 1'b0;
      @(negedge wr_free);
      wr_en_n = 1'b1;
    end else begin
      #131 wr_pulse = 1'b1;
      #160 wr_pulse = 1'b0;
      #160;
    end
    wr_data = ~d;
  endtask : put_word

  task automatic take_word(output logic [WIDTH-1:0] q);
    if (sync_mode) begin
      // enable low across one read clock rise
      @(negedge rd_free);
      rd_en_n = 1'b0;
      @(negedge rd_free);
      rd_en_n = 1'b1;
    end else begin
      #11 rd_pulse = 1'b1;
      #160 rd_pulse = 1'b0;
      #160;
    end
    #40 q = rd_data;
  endtask : take_word
endmodule : dcff_partner

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the dual clock buffer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct {logic sync; int n; logic [7:0] full_exp;} dcff_row_type;
  logic mclk, resetn, sync_mode, wr_clk, rd_clk, wr_en_n, rd_en_n;
  logic full_n, empty_n, full_seen, empty_seen;
  logic [7:0] wr_data, rd_data, q;
  dcff_pkg::dcff_strobe_type stage_strobes;
  int failures, num_checks;
  int strobe_count;
  dcff_row_type rows [5] = '{'{1'b0, 1, 8'h01}, '{1'b0, 5, 8'h01}, '{1'b0, 16, 8'h00},
    '{1'b1, 3, 8'h01}, '{1'b1, 16, 8'h00}};

  dcff_top dut (.mclk(mclk), .resetn(resetn), .wr_clk(wr_clk), .rd_clk(rd_clk),
    .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .style_sync(sync_mode), .wr_data(wr_data),
    .rd_data(rd_data), .full_n(full_n), .empty_n(empty_n), .stage_strobes(stage_strobes));
  dcff_partner u_far (.mclk(mclk), .sync_mode(sync_mode), .rd_data(rd_data), .full_n(full_n),
    .empty_n(empty_n), .wr_clk(wr_clk), .rd_clk(rd_clk), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n),
    .wr_data(wr_data), .full_seen(full_seen), .empty_seen(empty_seen));

  initial mclk = 1'b0;
  always #20 mclk = !mclk;

  // Counts words entering the chain through the entry stage
  always @(posedge mclk) begin
    strobe_count <= !resetn ? 0 : strobe_count + int'(stage_strobes.stage_strobe_first);
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_flag(input logic use_full, input logic lvl);
    int i;
    for (i = 0; i < 3000 && (use_full ? full_seen : empty_seen) !== lvl; i++) begin
      @(posedge mclk);
    end
    @(posedge mclk);
    #1;
    if (i == 3000) begin
      failures++;
      $display("unexpected flag wait: full %0d level %0d", use_full, lvl);
      end_sim();
    end
  endtask : wait_flag

  task automatic do_reset(input logic s);
    resetn = 1'b0;
    sync_mode = s;
    repeat (8) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic fill(input int n, input logic [7:0] base, input logic obey);
    for (int k = 0; k < n; k++) begin
      if (obey) wait_flag(1'b1, 1'b1);
      u_far.put_word(base + 8'(k));
    end
  endtask : fill

  task automatic drain(input int n, input logic [7:0] base, input logic solo);
    for (int k = 0; k < n; k++) begin
      wait_flag(1'b0, 1'b1);
      u_far.take_word(q);
      check("rd_data", q, base + 8'(k));
      if (solo) check("empty_n", empty_n, 8'(k < n - 1));
      if (k == 0) wait_flag(1'b1, 1'b1);
    end
  endtask : drain

  initial begin
    {resetn, sync_mode, failures, num_checks} = '0;
    do_reset(1'b0);
    check("full_n", full_n, 8'h01);
    check("empty_n", empty_n, 8'h00);
    check("rd_data", rd_data, 8'h00);
    $display("test reset done");
    foreach (rows[r]) begin
      do_reset(rows[r].sync);
      fill(rows[r].n, 8'hA0, 1'b1);
      wait_flag(1'b0, 1'b1);
      check("empty_n", empty_n, 8'h01);
      check("full_n", full_n, rows[r].full_exp);
      drain(rows[r].n, 8'hA0, 1'b1);
      check("strobes", 8'(strobe_count), 8'(rows[r].n));
      $display("test row %0d done", r);
    end
    // Write while full and read while empty are refused
    do_reset(1'b0);
    fill(16, 8'h30, 1'b1);
    wait_flag(1'b1, 1'b0);
    u_far.put_word(8'h55);
    check("full_n", full_n, 8'h00);
    drain(16, 8'h30, 1'b1);
    u_far.take_word(q);
    check("rd_data", q, 8'h3F);
    check("empty_n", empty_n, 8'h00);
    check("strobes", 8'(strobe_count), 8'h10);
    $display("test refusal done");
    // Writer and reader run at once in both styles
    for (int s = 0; s < 2; s++) begin
      do_reset(1'(s));
      fork
        fill(16, 8'hC0, 1'b1);
        drain(16, 8'hC0, 1'b0);
      join
      check("strobes", 8'(strobe_count), 8'h10);
      $display("test concurrent style %0d done", s);
    end
    end_sim();
  end
endmodule : testbench

`default_nettype wire
